//--- brake_aux_consts.vh
// Constants shared by the brake and auxiliary-circuit sequencer.
`ifndef BRAKE_AUX_CONSTS_VH
`define BRAKE_AUX_CONSTS_VH

// ----------------------------------------------------------------------
// Time base
// ----------------------------------------------------------------------
`define CLK_MHZ 20
`define TICK_US 1000
`define TICK_CYCLES (`TICK_US * `CLK_MHZ)

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ADDR_CTRL 8'h00
`define ADDR_REL_DLY 8'h04
`define ADDR_CLS_DLY 8'h08
`define ADDR_RAMP_DLY 8'h0c
`define ADDR_THR_A 8'h10
`define ADDR_THR_B 8'h14
`define ADDR_LEAD 8'h18
`define ADDR_TRAIL 8'h1c
`define ADDR_STATUS 8'h20

// ----------------------------------------------------------------------
// Field positions and encodings
// ----------------------------------------------------------------------
`define CTRL_TYPE_LSB 0
`define CTRL_TYPE_MSB 1
`define CTRL_OPT_LSB 8
`define CTRL_OPT_MSB 15
`define BRAKE_NONE 2'h0
`define BRAKE_HOLD 2'h1
`define BRAKE_OPER 2'h2
`define OPT_RUN_A 8'h17
`define OPT_RUN_B 8'h18
`define OPT_RUN_C 8'h19

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_CTRL 16'h0000
`define RST_DLY 16'h0000
`define RST_THR 16'h0064

`endif

//--- tick_gen.v
// Fixed time-base tick generator for the sequencing delays.
`timescale 1ns/1ps
module tick_gen #(
   parameter W = 16,
   parameter [W-1:0] CYCLES = 16'd20000
) (
   input wire clk,
   input wire rst_n,
   output reg tick
);
   localparam [W-1:0] LAST = CYCLES - {{(W-1){1'b0}}, 1'b1};
   reg [W-1:0] cnt_r;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= {W{1'b0}};
         tick <= 1'b0;
      end else if (cnt_r == LAST) begin
         cnt_r <= {W{1'b0}};
         tick <= 1'b1;
      end else begin
         cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
         tick <= 1'b0;
      end
   end
endmodule // tick_gen

//--- seq_timer.v
// Reloadable down-counter that measures a delay in time-base ticks.
`timescale 1ns/1ps
module seq_timer #(
   parameter W = 16
) (
   input wire clk,
   input wire rst_n,
   input wire tick,
   input wire load,
   input wire [W-1:0] value,
   output wire expired
);
   reg [W-1:0] count_r;

   // A load always wins over a tick, so a retrigger restarts the delay.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= {W{1'b0}};
      end else if (load) begin
         count_r <= value;
      end else if (tick && (count_r != {W{1'b0}})) begin
         count_r <= count_r - {{(W-1){1'b0}}, 1'b1};
      end
   end

   assign expired = (count_r == {W{1'b0}});
endmodule // seq_timer

//--- brake_aux_sequencer.v
// Brake, auxiliary-circuit and line-contactor sequencer for a DC drive.
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "brake_aux_consts.vh"
module brake_aux_sequencer #(
   parameter [15:0] TICK_CYCLES = `TICK_CYCLES,
   parameter DW = 16
) (
   input wire I_CLK,
   input wire I_RST_N,
   input wire [7:0] I_ADDR,
   input wire [15:0] I_WDATA,
   input wire I_WR,
   input wire I_RD,
   output reg [15:0] O_RDATA,
   input wire I_SWITCH_ON,
   input wire I_OP_ENABLE,
   input wire I_JOG,
   input wire I_CREEP,
   input wire I_QUICK_STOP,
   input wire I_DISCONNECT,
   input wire I_ESTOP,
   input wire [DW-1:0] I_SPEED,
   output reg O_BRAKE_CLOSE,
   output reg O_AUX_ON,
   output reg O_CONTACTOR_ON,
   output reg O_PULSE_EN,
   output reg O_TORQUE_EN,
   output reg O_SETPOINT_ZERO
);

   // -------------------------------------------------------------------
   // Sequencer states
   // -------------------------------------------------------------------
   localparam [3:0] S_OFF = 4'h0;
   localparam [3:0] S_WAIT = 4'h1;
   localparam [3:0] S_READY = 4'h2;
   localparam [3:0] S_REL = 4'h3;
   localparam [3:0] S_RUN = 4'h4;
   localparam [3:0] S_CLOSE = 4'h5;
   localparam [3:0] S_HOLD = 4'h6;
   localparam [3:0] S_COAST = 4'h7;
   localparam [3:0] S_TRAIL = 4'h8;

   // -------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------
   reg rst_meta_r;
   reg rst_sync_r;
   wire rst_n;
   wire tick;
   reg [15:0] ctrl_r;
   reg [15:0] rel_dly_r;
   reg [15:0] cls_dly_r;
   reg [15:0] ramp_dly_r;
   reg [DW-1:0] thr_a_r;
   reg [DW-1:0] thr_b_r;
   reg [15:0] lead_r;
   reg [15:0] trail_r;
   reg [3:0] state_r;
   reg [3:0] state_nxt;
   reg aux_r;
   reg aux_nxt;
   reg cont_r;
   reg cont_nxt;
   reg pulse_r;
   reg pulse_nxt;
   reg torque_r;
   reg torque_nxt;
   reg brake_r;
   reg brake_nxt;
   reg seq_load;
   reg [15:0] seq_val;
   wire seq_done;
   wire ramp_load;
   wire ramp_done;
   wire [1:0] brake_type;
   wire [7:0] opt_sel;
   wire opt_force;
   wire [DW-1:0] min_thr;
   wire slow;
   wire close_ok;
   wire on_cmd;
   wire run_en;
   wire rel_neg;
   wire [15:0] rel_mag;
   wire active;
   reg [15:0] rd_mux;

   // -------------------------------------------------------------------
   // Reset release
   // -------------------------------------------------------------------
   // The release is synchronised so every flop leaves reset on one edge.
   always @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   assign rst_n = rst_sync_r;

   // -------------------------------------------------------------------
   // Time base and delay counters
   // -------------------------------------------------------------------
   tick_gen #(
      .W(16),
      .CYCLES(TICK_CYCLES)
   ) u_tick (
      .clk(I_CLK),
      .rst_n(rst_n),
      .tick(tick)
   );

   // Lead, release, closing and trail delays never overlap in time, so
   // they share one counter that each state reloads on entry.
   seq_timer #(
      .W(16)
   ) u_seq_timer (
      .clk(I_CLK),
      .rst_n(rst_n),
      .tick(tick),
      .load(seq_load),
      .value(seq_val),
      .expired(seq_done)
   );

   seq_timer #(
      .W(16)
   ) u_ramp_timer (
      .clk(I_CLK),
      .rst_n(rst_n),
      .tick(tick),
      .load(ramp_load),
      .value(ramp_dly_r),
      .expired(ramp_done)
   );

   // -------------------------------------------------------------------
   // Command and configuration decode
   // -------------------------------------------------------------------
   assign on_cmd = (I_SWITCH_ON | I_JOG | I_CREEP) & ~I_QUICK_STOP;
   assign run_en = I_OP_ENABLE & ~I_DISCONNECT & ~I_ESTOP;
   assign brake_type = ctrl_r[`CTRL_TYPE_MSB:`CTRL_TYPE_LSB];
   assign opt_sel = ctrl_r[`CTRL_OPT_MSB:`CTRL_OPT_LSB];
   assign opt_force = (opt_sel == `OPT_RUN_A) | (opt_sel == `OPT_RUN_B) |
                      (opt_sel == `OPT_RUN_C);
   assign min_thr = (thr_a_r < thr_b_r) ? thr_a_r : thr_b_r;
   assign slow = (I_SPEED < min_thr);
   // An operational brake may close while turning; a holding brake
   // waits for standstill to spare its linings.
   assign close_ok = (brake_type != `BRAKE_HOLD) | slow;
   assign rel_neg = rel_dly_r[15];
   assign rel_mag = rel_neg ? (~rel_dly_r + 16'h0001) : rel_dly_r;
   assign active = (state_r == S_READY) | (state_r == S_REL) |
                   (state_r == S_RUN) | (state_r == S_CLOSE) |
                   (state_r == S_HOLD);

   // -------------------------------------------------------------------
   // Sequencer next state
   // -------------------------------------------------------------------
   always @* begin
      state_nxt = state_r;
      aux_nxt = aux_r;
      cont_nxt = cont_r;
      pulse_nxt = pulse_r;
      torque_nxt = torque_r;
      brake_nxt = brake_r;
      seq_load = 1'b0;
      seq_val = 16'h0000;
      case (state_r)
         S_OFF: begin
            if (on_cmd) begin
               aux_nxt = 1'b1;
               seq_load = 1'b1;
               seq_val = lead_r;
               state_nxt = S_WAIT;
            end
         end
         S_WAIT: begin
            if (!on_cmd) begin
               seq_load = 1'b1;
               seq_val = trail_r;
               state_nxt = S_TRAIL;
            end else if (seq_done) begin
               cont_nxt = 1'b1;
               state_nxt = S_READY;
            end
         end
         S_READY: begin
            if (run_en) begin
               pulse_nxt = 1'b1;
               seq_load = 1'b1;
               seq_val = rel_mag;
               if (rel_neg) begin
                  torque_nxt = 1'b1;
               end else begin
                  brake_nxt = 1'b0;
               end
               state_nxt = S_REL;
            end
         end
         S_REL: begin
            if (!run_en) begin
               state_nxt = S_CLOSE;
            end else if (seq_done) begin
               torque_nxt = 1'b1;
               brake_nxt = 1'b0;
               state_nxt = S_RUN;
            end
         end
         S_RUN: begin
            if (!run_en) begin
               state_nxt = S_CLOSE;
            end
         end
         S_CLOSE: begin
            if (close_ok) begin
               brake_nxt = 1'b1;
               seq_load = 1'b1;
               seq_val = cls_dly_r;
               state_nxt = S_HOLD;
            end
         end
         S_HOLD: begin
            if (seq_done) begin
               torque_nxt = 1'b0;
               pulse_nxt = 1'b0;
               state_nxt = S_READY;
            end
         end
         S_COAST: begin
            if (close_ok) begin
               brake_nxt = 1'b1;
            end
            if (slow) begin
               cont_nxt = 1'b0;
               seq_load = 1'b1;
               seq_val = trail_r;
               state_nxt = S_TRAIL;
            end
         end
         S_TRAIL: begin
            if (on_cmd) begin
               cont_nxt = 1'b1;
               state_nxt = S_READY;
            end else if (seq_done) begin
               aux_nxt = 1'b0;
               state_nxt = S_OFF;
            end
         end
         default: begin
            state_nxt = S_OFF;
         end
      endcase
      // Switch-off overrides any running step: pulses and torque go at
      // once, while the contactor waits for the drive to slow down.
      if (active && !on_cmd) begin
         pulse_nxt = 1'b0;
         torque_nxt = 1'b0;
         seq_load = 1'b0;
         state_nxt = S_COAST;
         if (close_ok) begin
            brake_nxt = 1'b1;
         end
      end
   end

   // Controller enable is the rising edge of torque enable.
   assign ramp_load = torque_nxt & ~torque_r;

   // -------------------------------------------------------------------
   // Sequencer state and outputs
   // -------------------------------------------------------------------
   always @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= S_OFF;
         aux_r <= 1'b0;
         cont_r <= 1'b0;
         pulse_r <= 1'b0;
         torque_r <= 1'b0;
         brake_r <= 1'b1;
         O_BRAKE_CLOSE <= 1'b0;
         O_AUX_ON <= 1'b0;
         O_CONTACTOR_ON <= 1'b0;
         O_PULSE_EN <= 1'b0;
         O_TORQUE_EN <= 1'b0;
         O_SETPOINT_ZERO <= 1'b1;
      end else begin
         state_r <= state_nxt;
         aux_r <= aux_nxt;
         cont_r <= cont_nxt;
         pulse_r <= pulse_nxt;
         torque_r <= torque_nxt;
         brake_r <= brake_nxt;
         // With no brake fitted the output stays open except when an
         // optimization run demands it.
         O_BRAKE_CLOSE <= ((brake_type != `BRAKE_NONE) & brake_nxt) |
                          opt_force;
         O_AUX_ON <= aux_nxt;
         O_CONTACTOR_ON <= cont_nxt;
         O_PULSE_EN <= pulse_nxt;
         O_TORQUE_EN <= torque_nxt;
         O_SETPOINT_ZERO <= ~torque_nxt | ramp_load | ~ramp_done;
      end
   end

   // -------------------------------------------------------------------
   // Register writes
   // -------------------------------------------------------------------
   always @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= `RST_CTRL;
         rel_dly_r <= `RST_DLY;
         cls_dly_r <= `RST_DLY;
         ramp_dly_r <= `RST_DLY;
         thr_a_r <= `RST_THR;
         thr_b_r <= `RST_THR;
         lead_r <= `RST_DLY;
         trail_r <= `RST_DLY;
      end else if (I_WR) begin
         case (I_ADDR)
            `ADDR_CTRL: begin
               ctrl_r <= I_WDATA;
            end
            `ADDR_REL_DLY: begin
               rel_dly_r <= I_WDATA;
            end
            `ADDR_CLS_DLY: begin
               cls_dly_r <= I_WDATA;
            end
            `ADDR_RAMP_DLY: begin
               ramp_dly_r <= I_WDATA;
            end
            `ADDR_THR_A: begin
               thr_a_r <= I_WDATA[DW-1:0];
            end
            `ADDR_THR_B: begin
               thr_b_r <= I_WDATA[DW-1:0];
            end
            `ADDR_LEAD: begin
               lead_r <= I_WDATA;
            end
            `ADDR_TRAIL: begin
               trail_r <= I_WDATA;
            end
            default: begin
               ctrl_r <= ctrl_r;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Register reads
   // -------------------------------------------------------------------
   always @* begin
      case (I_ADDR)
         `ADDR_CTRL: rd_mux = ctrl_r;
         `ADDR_REL_DLY: rd_mux = rel_dly_r;
         `ADDR_CLS_DLY: rd_mux = cls_dly_r;
         `ADDR_RAMP_DLY: rd_mux = ramp_dly_r;
         `ADDR_THR_A: rd_mux = thr_a_r;
         `ADDR_THR_B: rd_mux = thr_b_r;
         `ADDR_LEAD: rd_mux = lead_r;
         `ADDR_TRAIL: rd_mux = trail_r;
         `ADDR_STATUS: rd_mux = {state_r, 6'h00, O_SETPOINT_ZERO,
                                 O_TORQUE_EN, O_PULSE_EN, O_CONTACTOR_ON,
                                 O_AUX_ON, O_BRAKE_CLOSE};
         default: rd_mux = 16'h0000;
      endcase
   end

   // Read data stand for exactly the cycle after the strobe.
   always @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         O_RDATA <= 16'h0000;
      end else if (I_RD) begin
         O_RDATA <= rd_mux;
      end else begin
         O_RDATA <= 16'h0000;
      end
   end

endmodule // brake_aux_sequencer

//--- seq_asserts.sv
// Checker of the brake, auxiliary and contactor sequencing outputs.
`timescale 1ns/1ps
module seq_asserts #(
   parameter [15:0] TICK_CYCLES = 16'd4,
   parameter DW = 16
) (
   input wire I_CLK,
   input wire I_RST_N,
   input wire [7:0] I_ADDR,
   input wire [15:0] I_WDATA,
   input wire I_WR,
   input wire I_RD,
   input wire [15:0] O_RDATA,
   input wire I_SWITCH_ON,
   input wire I_OP_ENABLE,
   input wire I_JOG,
   input wire I_CREEP,
   input wire I_QUICK_STOP,
   input wire I_DISCONNECT,
   input wire I_ESTOP,
   input wire [DW-1:0] I_SPEED,
   input wire O_BRAKE_CLOSE,
   input wire O_AUX_ON,
   input wire O_CONTACTOR_ON,
   input wire O_PULSE_EN,
   input wire O_TORQUE_EN,
   input wire O_SETPOINT_ZERO
);
// ---
// Register mirror and wait counter
// ---
reg [1:0] ty;
reg [7:0] opt;
reg [15:0] ta, tb, ld, tr, wc;
reg [1:0] rdy;
reg fresh;
wire on = (I_SWITCH_ON | I_JOG | I_CREEP) & ~I_QUICK_STOP;
wire frc = opt >= 8'h17 && opt <= 8'h19;
wire [15:0] thr = ta < tb ? ta : tb;
// Fresh marks a start from OFF, so a trail restart is not held to lead time.
always @(posedge I_CLK or negedge I_RST_N) begin
   if (!I_RST_N) begin
      ty <= 2'h0;
      opt <= 8'h00;
      ta <= 16'h0064;
      tb <= 16'h0064;
      ld <= 16'h0000;
      tr <= 16'h0000;
      wc <= 16'h0000;
      rdy <= 2'h0;
      fresh <= 1'b1;
   end else begin
      if (rdy != 2'h3) rdy <= rdy + 2'h1;
      if (I_WR && I_ADDR == 8'h00) ty <= I_WDATA[1:0];
      if (I_WR && I_ADDR == 8'h00) opt <= I_WDATA[15:8];
      if (I_WR && I_ADDR == 8'h10) ta <= I_WDATA;
      if (I_WR && I_ADDR == 8'h14) tb <= I_WDATA;
      if (I_WR && I_ADDR == 8'h18) ld <= I_WDATA;
      if (I_WR && I_ADDR == 8'h1c) tr <= I_WDATA;
      if (!O_AUX_ON || O_CONTACTOR_ON) wc <= 16'h0000;
      else if (wc != 16'hffff) wc <= wc + 16'h0001;
      if (!O_AUX_ON) fresh <= 1'b1;
      else if (O_CONTACTOR_ON) fresh <= 1'b0;
   end
end
default clocking @(posedge I_CLK); endclocking
default disable iff (!I_RST_N);
a_aux_rise: assert property (
   &rdy && !O_AUX_ON && on |=> O_AUX_ON) else $error("aux late");
a_pulse_stop: assert property (
   O_PULSE_EN && !on |=> !O_PULSE_EN) else $error("pulses stay on");
a_contact_drop: assert property (
   $fell(O_CONTACTOR_ON) |-> $past(I_SPEED) < thr)
   else $error("contactor dropped at speed");
a_trail_time: assert property (
   $fell(O_AUX_ON) |-> wc + TICK_CYCLES >= 32'(tr) * TICK_CYCLES)
   else $error("aux off early");
a_lead_time: assert property (
   $rose(O_CONTACTOR_ON) && fresh |->
   wc + TICK_CYCLES >= 32'(ld) * TICK_CYCLES) else $error("lead short");
a_skip_wait: assert property (
   O_AUX_ON && !O_CONTACTOR_ON && !fresh && on |-> ##[1:2] O_CONTACTOR_ON)
   else $error("trail restart slow");
a_opt_force: assert property (
   frc && $past(frc) |-> O_BRAKE_CLOSE) else $error("opt force lost");
a_no_brake: assert property (
   ty == 2'h0 && $past(ty) == 2'h0 && !frc && !$past(frc) |->
   !O_BRAKE_CLOSE) else $error("brake without type");
a_hold_speed: assert property (
   ty == 2'h1 && $past(ty) == 2'h1 && !frc && $rose(O_BRAKE_CLOSE) |->
   $past(I_SPEED) < thr) else $error("holding brake at speed");
a_torque_pulse: assert property (
   O_TORQUE_EN |-> O_PULSE_EN) else $error("torque without pulses");
endmodule // seq_asserts
bind brake_aux_sequencer seq_asserts #(.TICK_CYCLES(TICK_CYCLES), .DW(DW))
   u_chk (.I_CLK, .I_RST_N, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA,
   .I_SWITCH_ON, .I_OP_ENABLE, .I_JOG, .I_CREEP, .I_QUICK_STOP,
   .I_DISCONNECT, .I_ESTOP, .I_SPEED, .O_BRAKE_CLOSE, .O_AUX_ON,
   .O_CONTACTOR_ON, .O_PULSE_EN, .O_TORQUE_EN, .O_SETPOINT_ZERO);

//--- motor_model.sv
// Motor model: speed follows torque and decays when coasting or braked.
`timescale 1ns/1ps
module motor_model (
   input wire clk,
   input wire torque,
   input wire brake,
   input wire [15:0] target,
   output reg [15:0] speed
);
initial speed = 16'h0000;
// A closed brake decelerates faster than coasting, as a real one would.
always @(posedge clk) begin
   if (torque && !brake && speed < target) speed <= speed + 16'h0001;
   else if (brake && speed >= 16'h0004) speed <= speed - 16'h0004;
   else if (speed != 16'h0000 && speed > target) speed <= speed - 16'h0001;
end
endmodule // motor_model

//--- brake_aux_sequencer_test.sv
// Self-checking bench of the brake and auxiliary sequencer.
`timescale 1ns/1ps
module brake_aux_sequencer_test;
reg I_CLK = 0, I_RST_N = 0, I_WR = 0, I_RD = 0, I_SWITCH_ON = 0;
reg I_OP_ENABLE = 0, I_JOG = 0, I_CREEP = 0, I_QUICK_STOP = 0;
reg I_DISCONNECT = 0, I_ESTOP = 0, rd_pend = 0;
reg [7:0] I_ADDR = 0;
reg [15:0] I_WDATA = 0, target = 0, thra;
wire [15:0] I_SPEED, O_RDATA;
wire O_BRAKE_CLOSE, O_AUX_ON, O_CONTACTOR_ON;
wire O_PULSE_EN, O_TORQUE_EN, O_SETPOINT_ZERO;
wire [5:0] outs = {O_SETPOINT_ZERO, O_TORQUE_EN, O_PULSE_EN,
   O_CONTACTOR_ON, O_AUX_ON, O_BRAKE_CLOSE};
integer err_total = 0, samples_checked = 0, seed = 32'he220, cyc = 0, k;
logic [15:0] exp_q[$], msk_q[$];
brake_aux_sequencer #(.TICK_CYCLES(16'd4)) u_dut (.I_CLK, .I_RST_N,
   .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA, .I_SWITCH_ON, .I_OP_ENABLE,
   .I_JOG, .I_CREEP, .I_QUICK_STOP, .I_DISCONNECT, .I_ESTOP, .I_SPEED,
   .O_BRAKE_CLOSE, .O_AUX_ON, .O_CONTACTOR_ON, .O_PULSE_EN, .O_TORQUE_EN,
   .O_SETPOINT_ZERO);
motor_model u_motor (.clk(I_CLK), .torque(O_TORQUE_EN),
   .brake(O_BRAKE_CLOSE), .target(target), .speed(I_SPEED));
initial forever #25 I_CLK = ~I_CLK;
// ---
// Tasks
// ---
task complete_run;
   $display("checks %0d mismatches %0d", samples_checked, err_total);
   if (err_total == 0 && samples_checked > 0) $display("bench passed");
   else $display("bench failed");
   $finish;
endtask
task cmp(input [15:0] got, input [15:0] ev);
   samples_checked = samples_checked + 1;
   if (got !== ev) begin
      err_total = err_total + 1;
      $display("mismatch at %0t got %h expected %h", $time, got, ev);
   end
endtask
task wr(input [7:0] a, input [15:0] d);
   @(posedge I_CLK);
   I_ADDR <= a;
   I_WDATA <= d;
   I_WR <= 1'b1;
   @(posedge I_CLK);
   I_WR <= 1'b0;
endtask
task rd(input [7:0] a, input [15:0] ev, input [15:0] m);
   exp_q.push_back(ev);
   msk_q.push_back(m);
   @(posedge I_CLK);
   I_ADDR <= a;
   I_RD <= 1'b1;
   @(posedge I_CLK);
   I_RD <= 1'b0;
   @(posedge I_CLK);
endtask
// Waits a bounded time for one output, then compares it.
task waitb(input integer i, input v, input integer n);
   integer c;
   c = 0;
   while (outs[i] !== v && c < n) begin
      @(negedge I_CLK);
      c = c + 1;
   end
   cmp({15'h0, outs[i]}, {15'h0, v});
   // Return on a rising edge so the next stimulus is driven there.
   @(posedge I_CLK);
endtask
always @(posedge I_CLK) rd_pend <= I_RD;
always @(negedge I_CLK) begin
   if (rd_pend) begin
      cmp(O_RDATA & msk_q.pop_front(), exp_q.pop_front());
   end
end
always @(posedge I_CLK) begin
   cyc = cyc + 1;
   if (cyc == 6000) begin
      err_total = err_total + 1;
      complete_run;
   end
end
// ---
// Main sequence
// ---
initial begin
   repeat (12) @(posedge I_CLK);
   I_RST_N <= 1'b1;
   repeat (3) @(posedge I_CLK);
   rd(8'h20, 16'h0020, 16'h003f);
   rd(8'h14, 16'h0064, 16'hffff);
   rd(8'h24, 16'h0000, 16'hffff);
   thra = 16'd40 + ($random(seed) & 16'h000f);
   wr(8'h10, thra);
   wr(8'h08, 16'h0002);
   wr(8'h0c, 16'h0001);
   wr(8'h18, 16'h0002);
   wr(8'h1c, 16'h0003);
   wr(8'h04, 16'h0002);
   wr(8'h00, 16'h0001);
   I_SWITCH_ON <= 1'b1;
   waitb(1, 1'b1, 2);
   rd(8'h20, 16'h1023, 16'hf03f);
   waitb(2, 1'b1, 20);
   rd(8'h20, 16'h2007, 16'hf01f);
   I_OP_ENABLE <= 1'b1;
   target <= 16'd100;
   waitb(0, 1'b0, 4);
   rd(8'h20, 16'h000e, 16'h001f);
   waitb(4, 1'b1, 16);
   waitb(5, 1'b0, 16);
   repeat (120) @(posedge I_CLK);
   I_ESTOP <= 1'b1;
   target <= 16'd0;
   waitb(0, 1'b1, 200);
   @(negedge I_CLK);
   cmp({15'h0, I_SPEED < thra}, 16'h0001);
   rd(8'h20, 16'h0019, 16'h0019);
   waitb(4, 1'b0, 16);
   waitb(3, 1'b0, 4);
   I_ESTOP <= 1'b0;
   I_OP_ENABLE <= 1'b0;
   wr(8'h00, 16'h0002);
   wr(8'h04, 16'hfffe);
   I_OP_ENABLE <= 1'b1;
   target <= 16'd100;
   waitb(4, 1'b1, 4);
   rd(8'h20, 16'h0019, 16'h0019);
   waitb(0, 1'b0, 16);
   repeat (120) @(posedge I_CLK);
   I_DISCONNECT <= 1'b1;
   waitb(0, 1'b1, 3);
   @(negedge I_CLK);
   cmp({15'h0, I_SPEED > thra}, 16'h0001);
   rd(8'h20, 16'h0019, 16'h0019);
   waitb(4, 1'b0, 16);
   I_DISCONNECT <= 1'b0;
   waitb(3, 1'b1, 4);
   repeat (120) @(posedge I_CLK);
   I_QUICK_STOP <= 1'b1;
   I_OP_ENABLE <= 1'b0;
   target <= 16'd0;
   waitb(3, 1'b0, 2);
   rd(8'h20, 16'h0004, 16'h0004);
   waitb(2, 1'b0, 60);
   I_QUICK_STOP <= 1'b0;
   waitb(2, 1'b1, 3);
   I_SWITCH_ON <= 1'b0;
   waitb(2, 1'b0, 10);
   waitb(1, 1'b0, 30);
   rd(8'h20, 16'h0000, 16'hf006);
   for (k = 0; k < 2; k = k + 1) begin
      if (k == 1) I_CREEP <= 1'b1;
      else I_JOG <= 1'b1;
      waitb(1, 1'b1, 2);
      I_JOG <= 1'b0;
      I_CREEP <= 1'b0;
      waitb(1, 1'b0, 30);
   end
   for (k = 0; k < 5; k = k + 1) begin
      wr(8'h00, {8'h16 + k[7:0], 8'h00});
      repeat (2) @(negedge I_CLK);
      cmp({15'h0, O_BRAKE_CLOSE}, {15'h0, k > 0 && k < 4});
   end
   complete_run;
end
endmodule // brake_aux_sequencer_test
